// ### src/ssib_pkg.sv
// Package of constants and types for the switch-stepped interval blinker
// How it works
// R01: Interval timer ticks each period, auto restarts
// R02: Initial compare value gives 2 ms tick
// R03: Timer pin output stays disabled always
// R04: 250 ticks invert LED, counter restarts
// R05: At tick 249 load pending reload value
// R06: Presses step half-period 500 down to 31.25
// R07: Switch interrupt on falling edge only
// R08: Each press advances count and pending reload
// R09: Idle until tick; counting happens on tick
// R10: Everything runs on one peripheral clock
// R11: Compare is count minus one, halving steps
// R12: Period is compare plus one; change at wrap
package ssib_pkg;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_HZ        = 100_000_000;          // Clock rate
   localparam int CLK_PER_MS    = CLK_HZ / 1000;        // Cycles per millisecond
   localparam int TICK_MS       = 2;                    // Base tick interval in ms
   localparam int BASE_COUNT    = CLK_PER_MS * TICK_MS; // Base period count
   localparam int TICKS_PER_INV = 250;                  // Ticks per LED inversion
   localparam int RELOAD_TICK   = 249;                  // Tick at which reload applies
   localparam int NUM_STEPS     = 5;                    // Number of period steps
   localparam int CMP_W         = 20;                   // Compare value width
   // ****************************************************************
   // APB register map
   // ****************************************************************
   localparam logic [7:0] ADDR_STATUS  = 8'h00; // Sticky event flags, read clears
   localparam logic [7:0] ADDR_MASK    = 8'h04; // Interrupt mask, 1 enables
   localparam logic [7:0] ADDR_CTRL    = 8'h08; // Bit 0 starts the timer
   localparam logic [7:0] ADDR_STATE   = 8'h0c; // LED, press and tick counts
   localparam logic [7:0] ADDR_COMPARE = 8'h10; // Active compare value
   localparam logic [7:0] ADDR_PENDING = 8'h14; // Pending reload value
   localparam logic [1:0] MASK_RST     = 2'h0;  // Mask reset value
   localparam logic       CTRL_RST     = 1'b1;  // Timer runs after reset
   localparam int         EV_TICK      = 0;     // Status bit of tick event
   localparam int         EV_SWITCH    = 1;     // Status bit of switch event
   // Edge detector states, one bit changes per step except LOW back to HIGH
   typedef enum logic [1:0] {SSIB_HIGH = 2'b00, SSIB_FELL = 2'b01, SSIB_LOW = 2'b11}
      ssib_edge_t;
   // Compare value for a step: base count halved per step, minus one
   function automatic logic [CMP_W-1:0] ssib_step_cmp(input logic [2:0] step);
      int c;
      c = (BASE_COUNT >> step) - 1; // R11
      return c[CMP_W-1:0];
   endfunction
endpackage

// ### src/ssib_interval_timer.sv
// Interval timer channel with compare reload at period end
`timescale 1ns/1ns
`default_nettype none
module ssib_interval_timer
   import ssib_pkg::*;
#(
   parameter int W = CMP_W
)(
   input  wire logic         mclk_in,
   input  wire logic         sys_rst_in,
   input  wire logic         run_in,
   input  wire logic [W-1:0] compare_in,
   output logic              tick_out
);
   // ****************************************************************
   // Down counter
   // ****************************************************************
   logic [W-1:0] cnt_q;   // Counts compare down to zero
   logic         armed_q; // Low until a first period is loaded after reset
   // Period is compare plus one; new compare is picked up only on wrap, while run is low, or in the first cycle after reset
   // The first cycle after reset only loads the compare: a zero count
   // there would otherwise raise a tick that ends no period
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         cnt_q    <= '0;
         tick_out <= 1'b0;
         armed_q  <= 1'b0;
      end
      else if (!run_in || !armed_q)
      begin
         cnt_q    <= compare_in; // R01
         tick_out <= 1'b0;
         armed_q  <= 1'b1;
      end
      else if (cnt_q == '0)
      begin
         cnt_q    <= compare_in; // R01 R12
         tick_out <= 1'b1;       // R01
      end
      else
      begin
         cnt_q    <= cnt_q - 1'b1;
         tick_out <= 1'b0;
      end
   end
   tick_period_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // R12
      tick_out |=> !tick_out) else $error("tick lasted more than one cycle");
endmodule
`default_nettype wire

// ### src/ssib_blinker.sv
// Switch-stepped interval blinker top with APB registers
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module ssib_blinker
   import ssib_pkg::*;
(
   input  wire logic        mclk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic        switch_input_pin_in,
   output logic             led_output_pin_out,
   output logic             timer_pin_out,
   output logic             irq_out
);
   // The interval timer ticks once per compare plus one cycles. Ticks are
   // counted here: one tick before an LED inversion the pending value is
   // copied into the compare, and the next tick inverts the LED. A falling
   // switch edge steps the pending value through five halving periods.
   // Limitation: the switch is not debounced, every synchronised falling
   // edge counts as a press. Software sees events through sticky status
   // bits, a mask and one level interrupt line.
   // ****************************************************************
   // State
   // ****************************************************************
   logic [CMP_W-1:0] interval_compare_value_q; // Compare used by the timer
   logic [CMP_W-1:0] pending_reload_value_q;   // Value applied at tick 249
   logic [7:0]       tick_counter_q;           // Ticks since last inversion
   logic [7:0]       press_counter_q;          // Switch presses seen
   logic [2:0]       step_q;                   // Current period step
   logic [1:0]       status_q;                 // Sticky event flags
   logic [1:0]       mask_q;                   // Interrupt enables
   logic             run_q;                    // Timer run control
   logic             sw_s1_q;                  // Synchroniser first stage
   logic             sw_s2_q;                  // Synchroniser second stage
   ssib_edge_t       edge_q;                   // Falling edge detector state
   logic             interval_tick_irq;        // One-cycle tick event
   logic             switch_edge_irq;          // One-cycle press event
   logic             rd_status;                // Status read accepted
   logic             wr;                       // Write accepted
   logic [2:0]       step_d;                   // Step after a press
   logic [1:0]       rd_clr;                   // Status bits a finished read returned

   // ****************************************************************
   // Timer channel, single clock domain
   // ****************************************************************
   ssib_interval_timer #(.W(CMP_W)) u_timer ( // R10
      .mclk_in    (mclk_in),
      .sys_rst_in (sys_rst_in),
      .run_in     (run_q),
      .compare_in (interval_compare_value_q),
      .tick_out   (interval_tick_irq)
   );

   // ****************************************************************
   // Switch synchroniser and falling edge detector
   // ****************************************************************
   // Pin is asynchronous, so two flops before anything looks at it
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         sw_s1_q <= 1'b1;
         sw_s2_q <= 1'b1;
      end
      else
      begin
         sw_s1_q <= switch_input_pin_in;
         sw_s2_q <= sw_s1_q;
      end
   end
   // Only a high to low transition counts; rising edges are ignored
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         edge_q <= SSIB_HIGH;
      else
      begin
         case (edge_q)
            SSIB_HIGH: edge_q <= sw_s2_q ? SSIB_HIGH : SSIB_FELL; // R07
            SSIB_FELL: edge_q <= sw_s2_q ? SSIB_HIGH : SSIB_LOW;
            SSIB_LOW:  edge_q <= sw_s2_q ? SSIB_HIGH : SSIB_LOW;
            default:   edge_q <= SSIB_HIGH;
         endcase
      end
   end
   assign switch_edge_irq = (edge_q == SSIB_FELL); // R07

   // ****************************************************************
   // Press handling
   // ****************************************************************
   assign step_d = (step_q == 3'(NUM_STEPS - 1)) ? 3'h0 : step_q + 3'h1; // R06
   // Press advances step and pending value; wraps after the fifth step
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         step_q                 <= 3'h0;
         press_counter_q        <= 8'h00;
         pending_reload_value_q <= ssib_step_cmp(3'h0); // R02
      end
      else if (switch_edge_irq)
      begin
         step_q                 <= step_d;                  // R08
         press_counter_q        <= press_counter_q + 8'h01; // R08
         pending_reload_value_q <= ssib_step_cmp(step_d);   // R06 R08 R11
      end
   end

   // ****************************************************************
   // Tick counting, compare reload and LED
   // ****************************************************************
   // Nothing happens between ticks; all work is done on the tick event
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         tick_counter_q           <= 8'h00;
         led_output_pin_out       <= 1'b0;
         interval_compare_value_q <= ssib_step_cmp(3'h0); // R02
      end
      else if (interval_tick_irq) // R09
      begin
         if (tick_counter_q == 8'(TICKS_PER_INV - 1))
         begin
            tick_counter_q     <= 8'h00;               // R04
            led_output_pin_out <= !led_output_pin_out; // R04
         end
         else
            tick_counter_q <= tick_counter_q + 8'h01;   // R04
         // Count becomes 249 on this tick: the timer picks the new period up at its next wrap
         if (tick_counter_q == 8'(RELOAD_TICK - 1))
            interval_compare_value_q <= pending_reload_value_q; // R05
      end
   end
   // The timer's own output pin is never enabled
   always_ff @(posedge mclk_in)
   begin
      timer_pin_out <= 1'b0; // R03
   end

   // ****************************************************************
   // APB slave, zero wait states
   // ****************************************************************
   assign wr        = psel_in && penable_in && pwrite_in;
   assign rd_status = psel_in && penable_in && !pwrite_in && paddr_in == ADDR_STATUS;
   // Writes to control and mask registers
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         mask_q <= MASK_RST;
         run_q  <= CTRL_RST;
      end
      else if (wr && paddr_in == ADDR_MASK)
         mask_q <= pwdata_in[1:0];
      else if (wr && paddr_in == ADDR_CTRL)
         run_q <= pwdata_in[0];
   end
   // Read data, registered; unmapped addresses read zero with error
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         prdata_out  <= 32'h0;
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
      end
      else
      begin
         pready_out  <= psel_in && !penable_in;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h0;
         if (psel_in && !penable_in)
         begin
            case (paddr_in)
               ADDR_STATUS:  prdata_out <= {30'h0, status_q};
               ADDR_MASK:    prdata_out <= {30'h0, mask_q};
               ADDR_CTRL:    prdata_out <= {31'h0, run_q};
               ADDR_STATE:   prdata_out <= {7'h0, led_output_pin_out,
                                            press_counter_q, 5'h0, step_q, tick_counter_q};
               ADDR_COMPARE: prdata_out <= {12'h0, interval_compare_value_q};
               ADDR_PENDING: prdata_out <= {12'h0, pending_reload_value_q};
               default:      pslverr_out <= 1'b1;
            endcase
         end
      end
   end

   // ****************************************************************
   // Interrupt status, read clears, set wins
   // ****************************************************************
   // Only the bits that the finishing read returned are cleared, so an
   // event landing between the setup snapshot and the access edge stays
   // pending instead of being lost
   assign rd_clr = (rd_status && pready_out) ? prdata_out[1:0] : 2'h0;
   // Event and clear in one cycle: the event wins
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         status_q <= 2'h0;
      else
      begin
         status_q[EV_TICK]   <= interval_tick_irq ||
                                (status_q[EV_TICK] && !rd_clr[EV_TICK]);
         status_q[EV_SWITCH] <= switch_edge_irq ||
                                (status_q[EV_SWITCH] && !rd_clr[EV_SWITCH]);
      end
   end
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         irq_out <= 1'b0;
      else
         irq_out <= |(status_q & mask_q);
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   // LED flips and the tick count restarts on the 250th tick
   led_invert_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // R04
      interval_tick_irq && tick_counter_q == 8'd249 |=>
      led_output_pin_out != $past(led_output_pin_out) && tick_counter_q == 8'd0)
      else $error("LED not inverted on 250th tick");
   // Every other tick just counts up by one
   tick_count_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // R04
      interval_tick_irq && tick_counter_q != 8'd249 |=>
      tick_counter_q == $past(tick_counter_q) + 8'd1)
      else $error("tick counter did not advance");
   // Between ticks nothing moves
   led_hold_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // R09
      !interval_tick_irq |=> $stable(led_output_pin_out))
      else $error("LED changed without a tick");
   tick_hold_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // R09
      !interval_tick_irq |=> $stable(tick_counter_q))
      else $error("tick counter moved without a tick");
   // Pending value reaches the timer one tick before the inversion
   reload_apply_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // R05
      interval_tick_irq && tick_counter_q == 8'd248 |=>
      interval_compare_value_q == $past(pending_reload_value_q))
      else $error("compare not reloaded at tick 249");
   // A press bumps the count and loads the next step's compare
   press_step_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // R08
      switch_edge_irq |=> press_counter_q == $past(press_counter_q) + 8'd1
      && pending_reload_value_q == ssib_step_cmp(step_q))
      else $error("press did not advance");
   // After the shortest period the next press returns to the longest
   step_wrap_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // R06
      switch_edge_irq && step_q == 3'd4 |=> step_q == 3'd0
      && pending_reload_value_q == ssib_step_cmp(3'h0))
      else $error("step did not wrap");
   // A press event always follows a high then low synchronised level
   falling_only_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // R07
      switch_edge_irq |-> $past(sw_s2_q, 2) && !$past(sw_s2_q))
      else $error("edge event without falling edge");
   pin_off_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // R03
      ##1 !timer_pin_out) else $error("timer pin driven");
   tick_space_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // R01
      interval_tick_irq && run_q |=> !interval_tick_irq [*2])
      else $error("ticks too close");
   cmp_stable_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // R12
      !interval_tick_irq |=> $stable(interval_compare_value_q))
      else $error("compare changed mid period");
   // The switch status flag is set by its event, whatever the bus does
   status_set_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // R07 R08
      switch_edge_irq |=> status_q[EV_SWITCH])
      else $error("press not flagged");
   // A finished status read clears exactly the bits that it returned
   status_clear_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      rd_status && pready_out && !interval_tick_irq && !switch_edge_irq |=>
      status_q == ($past(status_q) & ~$past(prdata_out[1:0])))
      else $error("status read did not clear");
   // Interrupt line follows the masked flags one cycle later
   irq_level_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      ##1 irq_out == $past(|(status_q & mask_q)))
      else $error("interrupt line wrong");
   // Ready stands for the access cycle only; error rides with ready
   ready_pulse_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      pready_out |=> !pready_out)
      else $error("ready stood two cycles");
   slverr_ready_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      pslverr_out |-> pready_out)
      else $error("error without ready");
   // A mask write lands at the access edge
   mask_write_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      wr && paddr_in == ADDR_MASK |=> mask_q == $past(pwdata_in[1:0]))
      else $error("mask write lost");
   cv_tick_c: cover property (@(posedge mclk_in) interval_tick_irq);
   cv_led_c: cover property (@(posedge mclk_in) $changed(led_output_pin_out));
   cv_press_c: cover property (@(posedge mclk_in) switch_edge_irq);
   cv_irq_c: cover property (@(posedge mclk_in) $rose(irq_out));
   cv_wrap_c: cover property (@(posedge mclk_in) switch_edge_irq && step_q == 3'd4);
endmodule
`default_nettype wire

// ### sim/ssib_switch_model.sv
// Push switch and LED partner model for the interval blinker
`timescale 1ns/1ns
`default_nettype none
module ssib_switch_model
(
   input  wire logic      mclk_in,       // System clock
   input  wire logic      led_level_in,  // LED pin level from the block
   output var  logic      sw_level_out,  // Switch line, pulled up when open
   output var  logic [7:0] led_flips_out // Count of LED level changes
);
   logic led_q; // Last LED level seen
   initial
   begin
      sw_level_out  = 1'b1;
      led_flips_out = 8'h00;
      led_q         = 1'b0;
   end
   // ****************************************************************
   // LED watcher: an unknown level never counts as a change
   // ****************************************************************
   always @(posedge mclk_in)
   begin
      if ((led_level_in ^ led_q) === 1'b1)
         led_flips_out <= led_flips_out + 8'h01;
      led_q <= led_level_in;
   end
   // Press: pull low for lo cycles, release to the pull-up for hi cycles
   task automatic press(input int lo, input int hi);
      @(posedge mclk_in);
      sw_level_out <= 1'b0;
      repeat (lo) @(posedge mclk_in);
      sw_level_out <= 1'b1;
      repeat (hi) @(posedge mclk_in);
   endtask
endmodule
`default_nettype wire

// ### sim/switch_stepped_interval_blinker_test.sv
// Self-checking bench for the switch-stepped interval blinker
`timescale 1ns/1ns
`default_nettype none
module switch_stepped_interval_blinker_test
   import ssib_pkg::*;
;
   logic        mclk_in, sys_rst_in, psel, penable, pwrite, er, m;
   logic [7:0]  paddr, flips;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, sw_pin, led, tpin, irq;
   int          err_count, cmp_count, step, presses, i;
   int          pend_q[$]; // Expected compare value per step
   ssib_blinker dut_u (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .switch_input_pin_in(sw_pin), .led_output_pin_out(led), .timer_pin_out(tpin),
      .irq_out(irq));
   ssib_switch_model sw_u (.mclk_in(mclk_in), .led_level_in(led), .sw_level_out(sw_pin),
      .led_flips_out(flips));
   // ****************************************************************
   // Reporting
   // ****************************************************************
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask
   // APB transfer; holds the request until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge mclk_in);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge mclk_in);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge mclk_in);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         err_count++;
         wrap_up();
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // Reset state of the registers and pins
   task automatic check_reset;
      apb(1'b0, ADDR_COMPARE, 32'h0);
      chk("compare", pend_q[0], rd);
      chk("slverr clear", 32'h0, {31'h0, er});
      apb(1'b0, ADDR_PENDING, 32'h0);
      chk("pending", pend_q[0], rd);
      apb(1'b0, ADDR_STATE, 32'h0);
      chk("state", 32'h0, rd);
      apb(1'b0, ADDR_MASK, 32'h0);
      chk("mask", 32'h0, rd);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("run", 32'h1, rd);
      chk("timer pin", 32'h0, {31'h0, tpin});
   endtask
   initial
   begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   // Hang guard: the whole run stays well below one base tick
   initial
   begin
      repeat (100000) @(posedge mclk_in);
      err_count++;
      wrap_up();
   end
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      sys_rst_in = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      err_count = 0;
      cmp_count = 0;
      step = 0;
      presses = 0;
      void'($urandom(70765));
      for (i = 0; i < NUM_STEPS; i++)
         pend_q.push_back((BASE_COUNT >> i) - 1);
      repeat (5) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      check_reset();
      // Unmapped place: write ignored, read zero, error flagged
      apb(1'b1, 8'h18, $urandom);
      chk("slverr", 32'h1, {31'h0, er});
      apb(1'b0, 8'h18, 32'h0);
      chk("unmapped", 32'h1, {rd[30:0], er});
      apb(1'b1, ADDR_CTRL, 32'h0);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("run off", 32'h0, rd);
      apb(1'b1, ADDR_CTRL, 32'h1);
      // Seven presses cross the step wrap, irq masked every other time
      for (i = 1; i <= 7; i++)
      begin
         m = i[0];
         apb(1'b1, ADDR_MASK, {30'h0, m, 1'b0});
         sw_u.press(4 + $urandom % 8, 4 + $urandom % 8);
         step = (step + 1) % NUM_STEPS;
         presses++;
         chk("irq", {31'h0, m}, {31'h0, irq});
         apb(1'b0, ADDR_STATUS, 32'h0);
         chk("status", 32'h2, rd);
         apb(1'b0, ADDR_STATUS, 32'h0);
         chk("status clear", 32'h0, rd);
         chk("irq clear", 32'h0, {31'h0, irq});
         apb(1'b0, ADDR_PENDING, 32'h0);
         chk("pending", pend_q[step], rd);
         apb(1'b0, ADDR_COMPARE, 32'h0);
         chk("compare", pend_q[0], rd);
         apb(1'b0, ADDR_STATE, 32'h0);
         chk("state", (presses << 16) | (step << 8), rd);
      end
      chk("led flips", 32'h0, {24'h0, flips});
      // Second reset in mid-run
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      check_reset();
      wrap_up();
   end
endmodule
`default_nettype wire
